// >>> verilog/mmac_access_ctrl.sv
// mode based address mapping and access control for memory and sfr accesses
`timescale 1ns/1ns
module mmac_access_ctrl (
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu state
  input wire logic [7:0] program_status_upper,
  output mmac_pkg::mmac_mode_t cpu_mode,
  // cpu memory port
  input wire logic cpu_mem_req,
  input wire mmac_pkg::mmac_mem_req_t cpu_mem,
  output logic cpu_mem_done,
  output logic cpu_mem_violation,
  // physical memory port
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // cpu sfr port
  input wire logic cpu_sfr_req,
  input wire logic cpu_sfr_we,
  input wire logic [7:0] cpu_sfr_addr,
  input wire logic [7:0] cpu_sfr_wdata,
  output logic [7:0] cpu_sfr_rdata,
  output logic cpu_sfr_done,
  output logic cpu_sfr_violation,
  // sfr file port
  input wire logic [7:0] sfr_file_rdata,
  output logic sfr_file_we,
  output logic [7:0] sfr_file_addr,
  output logic [7:0] sfr_file_wdata
);
  import mmac_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_CMP,
    ST_DONE
  } mmac_state_t;

  // registers
  logic [1:0] imode_q;
  logic [6:0] table_ptr_q;
  logic [6:0] seg_index_q;
  logic [15:0] seg_first_q, seg_last_q, seg_offset_q;
  logic [15:0] viol_addr_q;
  logic [31:0] rdata_q;
  logic wait_q;
  mmac_state_t state_q;
  mmac_mem_req_t req_q;
  logic [6:0] scan_q;
  logic cur_hw_q;
  logic done_q, viol_q, mreq_q, mwe_q;
  logic [15:0] maddr_q;
  logic [7:0] mwdata_q;
  logic sdone_q, sviol_q, swe_q;
  logic [7:0] srdata_q, saddr_q, swdata_q;
  mmac_mode_t mode_q;
  mmac_seg_t seg_rd;

  // bus decode
  wire bus_wr = avs_write && !wait_q;
  wire rights_wr = bus_wr && avs_address == OFS_SEG_RIGHTS;
  wire busy = state_q != ST_IDLE;

  // mode derivation
  mmac_mode_t mode_d;
  assign mode_d = (imode_q == IMODE_BOOT) ? MODE_BOOT :
                  (imode_q == IMODE_TEST) ? MODE_TEST :
                  (imode_q == IMODE_CLS) ? MODE_CLS :
                  program_status_upper[PSU_SYSTEM_BIT] ? MODE_SYSTEM : MODE_USER;

  // descriptor store
  wire [6:0] rd_idx = table_ptr_q + scan_q[6:0];
  mmac_seg_t seg_wr;
  // one driver for the whole word, not one per field
  assign seg_wr = '{
    rd: avs_writedata[0],
    wr: avs_writedata[1],
    ex: avs_writedata[2],
    hw: avs_writedata[3],
    first: seg_first_q,
    last: seg_last_q,
    offset: seg_offset_q};

  mmac_desc_store #(
    .DEPTH(STORE_DEPTH),
    .AW(STORE_AW)
  ) u_store (
    .clk(clk),
    .wr_en(rights_wr),
    .wr_idx(seg_index_q),
    .wr_data(seg_wr),
    .rd_idx(rd_idx),
    .rd_data_q(seg_rd)
  );

  // physical region of an address
  function automatic mmac_region_t region_of(input logic [15:0] a);
    mmac_region_t r;
    r = REG_TEST_ROM;
    if (a >= RAM_BASE) r = REG_RAM;
    else if (a >= APP_EE_BASE) r = REG_APP_EE;
    else if (a >= CFG_EE_BASE) r = REG_CFG_EE;
    else if (a >= APP_ROM_BASE) r = REG_APP_ROM;
    return r;
  endfunction : region_of

  // fixed partition rights per mode
  function automatic logic part_ok(input mmac_mode_t m, input mmac_region_t r,
                                   input mmac_op_t op);
    logic rx, rwx, rw;
    rx = op != OP_WRITE;
    rwx = 1'b1;
    rw = op != OP_EXEC;
    part_ok = 1'b0;
    unique case (m)
      MODE_BOOT: part_ok = (r == REG_TEST_ROM && rx) || (r == REG_CFG_EE && rwx) ||
                           (r == REG_RAM && rw);
      MODE_TEST: part_ok = ((r == REG_TEST_ROM || r == REG_APP_ROM) && rx) ||
                           ((r == REG_CFG_EE || r == REG_APP_EE) && rwx) ||
                           (r == REG_RAM && rw);
      MODE_CLS: part_ok = (r == REG_TEST_ROM && rx) || (r == REG_CFG_EE && rwx);
      MODE_SYSTEM, MODE_USER: part_ok = (r == REG_APP_ROM && rx) ||
                                        (r == REG_APP_EE && rwx) || (r == REG_RAM && rw);
    endcase
    return part_ok;
  endfunction : part_ok

  // segment compare for the descriptor being scanned
  wire seg_enabled = seg_rd.rd || seg_rd.wr || seg_rd.ex;
  wire seg_in_range = req_q.addr >= seg_rd.first && req_q.addr <= seg_rd.last;
  wire seg_right = (req_q.op == OP_READ && seg_rd.rd) ||
                   (req_q.op == OP_WRITE && seg_rd.wr) ||
                   (req_q.op == OP_EXEC && seg_rd.ex);
  wire seg_hit = seg_enabled && seg_in_range;
  wire [15:0] seg_phys = req_q.addr + seg_rd.offset;
  wire seg_grant = seg_hit && seg_right && part_ok(mode_q, region_of(seg_phys), req_q.op);
  wire scan_last = scan_q == 7'(SEG_COUNT - 1);

  // non user modes map virtual onto physical one to one
  wire direct_grant = part_ok(mode_d, region_of(cpu_mem.addr), cpu_mem.op);

  // sfr permission
  mmac_sfr_grp_t grp;
  assign grp = (cpu_sfr_addr >= SFR_CPU_BASE) ? GRP_CPU :
               (cpu_sfr_addr >= SFR_HW_BASE) ? GRP_HW :
               (cpu_sfr_addr >= SFR_TEST_BASE) ? GRP_TEST :
               (cpu_sfr_addr >= SFR_SYSMGT_BASE) ? GRP_SYSMGT : GRP_SEGCFG;
  logic sfr_ok;
  always_comb begin
    sfr_ok = 1'b0;
    unique case (mode_d)
      MODE_BOOT, MODE_TEST: sfr_ok = 1'b1;
      MODE_CLS: sfr_ok = grp == GRP_HW;
      MODE_SYSTEM: sfr_ok = grp == GRP_HW || grp == GRP_SYSMGT || grp == GRP_SEGCFG;
      MODE_USER: sfr_ok = grp == GRP_HW && cur_hw_q;
    endcase
    if (grp == GRP_CPU) sfr_ok = 1'b1;
    if (cpu_sfr_addr == SFR_PSU_ADDR && !cpu_sfr_we &&
        (mode_d == MODE_CLS || mode_d == MODE_USER)) sfr_ok = 1'b1;
  end

  // register read mux
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0;
    unique case (avs_address)
      OFS_CTRL: rdata_d = {30'h0, imode_q};
      OFS_STATUS: rdata_d = {24'h0, cur_hw_q, viol_q, busy, 2'h0, mode_q};
      OFS_TABLE_PTR: rdata_d = {25'h0, table_ptr_q};
      OFS_SEG_INDEX: rdata_d = {25'h0, seg_index_q};
      OFS_SEG_FIRST: rdata_d = {16'h0, seg_first_q};
      OFS_SEG_LAST: rdata_d = {16'h0, seg_last_q};
      OFS_SEG_OFFSET: rdata_d = {16'h0, seg_offset_q};
      OFS_VIOL_ADDR: rdata_d = {16'h0, viol_addr_q};
      default: rdata_d = 32'h0;
    endcase
  end

  // avalon slave: one wait cycle, read data captured on the release edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      imode_q <= CTRL_RESET;
      table_ptr_q <= TABLE_PTR_RESET;
      seg_index_q <= 7'h0;
      seg_first_q <= 16'h0;
      seg_last_q <= 16'h0;
      seg_offset_q <= 16'h0;
    end else if (bus_wr) begin
      if (avs_address == OFS_CTRL) imode_q <= avs_writedata[1:0];
      if (avs_address == OFS_TABLE_PTR) table_ptr_q <= avs_writedata[6:0];
      if (avs_address == OFS_SEG_INDEX) seg_index_q <= avs_writedata[6:0];
      if (avs_address == OFS_SEG_FIRST) seg_first_q <= avs_writedata[15:0];
      if (avs_address == OFS_SEG_LAST) seg_last_q <= avs_writedata[15:0];
      if (avs_address == OFS_SEG_OFFSET) seg_offset_q <= avs_writedata[15:0];
    end
  end

  // memory access sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      scan_q <= 7'h0;
      mode_q <= MODE_BOOT;
      done_q <= 1'b0;
      viol_q <= 1'b0;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      maddr_q <= 16'h0;
      mwdata_q <= 8'h0;
      viol_addr_q <= 16'h0;
      cur_hw_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      done_q <= 1'b0;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (cpu_mem_req) begin
            req_q <= cpu_mem;
            scan_q <= 7'h0;
            if (mode_d == MODE_USER) begin
              state_q <= ST_FETCH;
            end else begin
              state_q <= ST_DONE;
              done_q <= 1'b1;
              viol_q <= !direct_grant;
              mreq_q <= direct_grant;
              mwe_q <= direct_grant && cpu_mem.op == OP_WRITE;
              maddr_q <= cpu_mem.addr;
              mwdata_q <= cpu_mem.wdata;
              if (!direct_grant) viol_addr_q <= cpu_mem.addr;
            end
          end
        end
        ST_FETCH: state_q <= ST_CMP;
        ST_CMP: begin
          if (seg_grant) begin
            state_q <= ST_DONE;
            done_q <= 1'b1;
            viol_q <= 1'b0;
            mreq_q <= 1'b1;
            mwe_q <= req_q.op == OP_WRITE;
            maddr_q <= seg_phys;
            mwdata_q <= req_q.wdata;
            if (req_q.op == OP_EXEC) cur_hw_q <= seg_rd.hw;
          end else if (scan_last) begin
            state_q <= ST_DONE;
            done_q <= 1'b1;
            viol_q <= 1'b1;
            viol_addr_q <= req_q.addr;
          end else begin
            // first granting segment decides; after a hit without the right, later ones are still searched
            scan_q <= scan_q + 7'h1;
            state_q <= ST_FETCH;
          end
        end
        ST_DONE: begin
          // wait for the cpu to drop its request so one request gives one answer
          if (!cpu_mem_req) state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sfr path, one cycle from request to answer
  always_ff @(posedge clk) begin
    if (rst) begin
      sdone_q <= 1'b0;
      sviol_q <= 1'b0;
      swe_q <= 1'b0;
      srdata_q <= 8'h0;
      saddr_q <= 8'h0;
      swdata_q <= 8'h0;
    end else begin
      sdone_q <= cpu_sfr_req;
      sviol_q <= cpu_sfr_req && !sfr_ok;
      swe_q <= cpu_sfr_req && cpu_sfr_we && sfr_ok;
      saddr_q <= cpu_sfr_addr;
      swdata_q <= cpu_sfr_wdata;
      srdata_q <= (cpu_sfr_req && !cpu_sfr_we && sfr_ok) ? sfr_file_rdata : 8'h0;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign cpu_mode = mode_q;
  assign cpu_mem_done = done_q;
  assign cpu_mem_violation = viol_q;
  assign mem_req = mreq_q;
  assign mem_addr = maddr_q;
  assign mem_we = mwe_q;
  assign mem_wdata = mwdata_q;
  assign cpu_sfr_rdata = srdata_q;
  assign cpu_sfr_done = sdone_q;
  assign cpu_sfr_violation = sviol_q;
  assign sfr_file_we = swe_q;
  assign sfr_file_addr = saddr_q;
  assign sfr_file_wdata = swdata_q;

endmodule : mmac_access_ctrl

// >>> shared/mmac_pkg.sv
// shared constants and types for the mode based memory access control block
package mmac_pkg;

  // cpu modes, boot/test/cls come from internal bits, system/user from the upper status word
  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_CLS,
    MODE_SYSTEM,
    MODE_USER
  } mmac_mode_t;

  // internal mode bit encodings
  localparam logic [1:0] IMODE_STATUS = 2'h0;
  localparam logic [1:0] IMODE_BOOT = 2'h1;
  localparam logic [1:0] IMODE_TEST = 2'h2;
  localparam logic [1:0] IMODE_CLS = 2'h3;
  // bit of program_status_upper that selects system mode
  localparam int PSU_SYSTEM_BIT = 7;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_EXEC
  } mmac_op_t;

  // physical memory partitions
  typedef enum logic [2:0] {
    REG_TEST_ROM,
    REG_APP_ROM,
    REG_CFG_EE,
    REG_APP_EE,
    REG_RAM
  } mmac_region_t;

  localparam logic [15:0] APP_ROM_BASE = 16'h1000;
  localparam logic [15:0] CFG_EE_BASE = 16'h8000;
  localparam logic [15:0] APP_EE_BASE = 16'h8800;
  localparam logic [15:0] RAM_BASE = 16'hc000;

  // special function register groups by address
  typedef enum logic [2:0] {
    GRP_SEGCFG,
    GRP_SYSMGT,
    GRP_TEST,
    GRP_HW,
    GRP_CPU
  } mmac_sfr_grp_t;

  localparam logic [7:0] SFR_SYSMGT_BASE = 8'h10;
  localparam logic [7:0] SFR_TEST_BASE = 8'h20;
  localparam logic [7:0] SFR_HW_BASE = 8'h40;
  localparam logic [7:0] SFR_CPU_BASE = 8'hc0;
  localparam logic [7:0] SFR_PSU_ADDR = 8'h10;

  // one descriptor of the segment_descriptor_table
  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
    logic hw;
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] offset;
  } mmac_seg_t;

  typedef struct packed {
    logic [15:0] addr;
    mmac_op_t op;
    logic [7:0] wdata;
  } mmac_mem_req_t;

  localparam int SEG_COUNT = 64;
  localparam int STORE_DEPTH = 128;
  localparam int STORE_AW = 7;

  // avalon register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TABLE_PTR = 8'h08;
  localparam logic [7:0] OFS_SEG_INDEX = 8'h0c;
  localparam logic [7:0] OFS_SEG_FIRST = 8'h10;
  localparam logic [7:0] OFS_SEG_LAST = 8'h14;
  localparam logic [7:0] OFS_SEG_OFFSET = 8'h18;
  localparam logic [7:0] OFS_SEG_RIGHTS = 8'h1c;
  localparam logic [7:0] OFS_VIOL_ADDR = 8'h20;

  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [6:0] TABLE_PTR_RESET = 7'h00;

endpackage : mmac_pkg

// >>> verilog/mmac_desc_store.sv
// descriptor storage with one write port and a registered read port
`timescale 1ns/1ns
module mmac_desc_store #(
  parameter int DEPTH = mmac_pkg::STORE_DEPTH,
  parameter int AW = mmac_pkg::STORE_AW
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire mmac_pkg::mmac_seg_t wr_data,
  input wire logic [AW-1:0] rd_idx,
  output mmac_pkg::mmac_seg_t rd_data_q
);
  import mmac_pkg::*;

  mmac_seg_t mem_q [DEPTH];

  // no reset: contents are undefined until software loads them
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
    rd_data_q <= mem_q[rd_idx];
  end

endmodule : mmac_desc_store

// >>> dv/mmac_access_ctrl_properties.sv
// port level assertions for the access control block
`timescale 1ns/1ns
module mmac_access_ctrl_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire mmac_pkg::mmac_mode_t cpu_mode,
  input wire logic cpu_mem_req,
  input wire mmac_pkg::mmac_mem_req_t cpu_mem,
  input wire logic cpu_mem_done,
  input wire logic cpu_mem_violation,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic cpu_sfr_req,
  input wire logic cpu_sfr_we,
  input wire logic [7:0] cpu_sfr_addr,
  input wire logic [7:0] cpu_sfr_wdata,
  input wire logic [7:0] cpu_sfr_rdata,
  input wire logic cpu_sfr_done,
  input wire logic cpu_sfr_violation,
  input wire logic [7:0] sfr_file_rdata,
  input wire logic sfr_file_we,
  input wire logic [7:0] sfr_file_addr,
  input wire logic [7:0] sfr_file_wdata
);
  import mmac_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // request edges; the held level after done is not a new request
  sequence take_fast; $rose(cpu_mem_req) && cpu_mode != MODE_USER; endsequence
  sequence take_scan; $rose(cpu_mem_req) && cpu_mode == MODE_USER; endsequence
  sequence rd_req; cpu_sfr_req && !cpu_sfr_we; endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  fast_answer_a: assert property (take_fast |=> cpu_mem_done)
    else $error("memory answer late");
  scan_bound_a: assert property (take_scan |=> !cpu_mem_done ##[1:129] cpu_mem_done)
    else $error("scan answer out of bounds");
  fast_ident_a: assert property (take_fast ##1 mem_req |-> mem_addr == $past(cpu_mem.addr))
    else $error("identity map broken");
  grant_clean_a: assert property (mem_req |-> cpu_mem_done && !cpu_mem_violation)
    else $error("grant without done");
  refuse_quiet_a: assert property (cpu_mem_done && cpu_mem_violation |-> !mem_req && !mem_we)
    else $error("refused access reached memory");
  we_pair_a: assert property (mem_we |-> mem_req && cpu_mem.op == OP_WRITE)
    else $error("memory write without write request");
  sfr_answer_a: assert property (1'b1 |=> cpu_sfr_done == $past(cpu_sfr_req))
    else $error("sfr answer timing");
  sfr_zero_a: assert property (rd_req |=> !cpu_sfr_violation || cpu_sfr_rdata == 8'h00)
    else $error("refused read not zero");
  sfr_pass_a: assert property (rd_req |=> cpu_sfr_violation || cpu_sfr_rdata == $past(sfr_file_rdata))
    else $error("granted read data wrong");
  sfr_drop_a: assert property (cpu_sfr_req && cpu_sfr_we |=> sfr_file_we == !cpu_sfr_violation
    && (!sfr_file_we || (sfr_file_addr == $past(cpu_sfr_addr)
    && sfr_file_wdata == $past(cpu_sfr_wdata))))
    else $error("sfr write gating wrong");
  cpu_open_a: assert property (cpu_sfr_req && cpu_sfr_addr >= SFR_CPU_BASE |=> !cpu_sfr_violation)
    else $error("cpu register refused");
endmodule : mmac_access_ctrl_properties

// >>> dv/mmac_cpu_model.sv
// cpu core and sfr file model facing the access control block
`timescale 1ns/1ns
module mmac_cpu_model (
  input wire logic clk,
  output logic cpu_mem_req,
  output mmac_pkg::mmac_mem_req_t cpu_mem,
  input wire logic cpu_mem_done,
  input wire logic cpu_mem_violation,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  output logic cpu_sfr_req,
  output logic cpu_sfr_we,
  output logic [7:0] cpu_sfr_addr,
  output logic [7:0] cpu_sfr_wdata,
  input wire logic [7:0] cpu_sfr_rdata,
  input wire logic cpu_sfr_violation,
  output logic [7:0] sfr_file_rdata,
  input wire logic sfr_file_we,
  input wire logic [7:0] sfr_file_addr,
  input wire logic [7:0] sfr_file_wdata
);
  import mmac_pkg::*;
  logic [7:0] file_q [256];
  initial begin
    cpu_mem_req = 1'b0;
    cpu_mem = '0;
    cpu_sfr_req = 1'b0;
    cpu_sfr_we = 1'b0;
    cpu_sfr_addr = 8'h00;
    cpu_sfr_wdata = 8'h00;
    for (int i = 0; i < 256; i++) file_q[i] = 8'(i) ^ 8'h5a;
  end
  assign sfr_file_rdata = file_q[cpu_sfr_addr];
  always @(posedge clk) if (sfr_file_we) file_q[sfr_file_addr] <= sfr_file_wdata;
  task automatic sfr_op(input logic we, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic viol);
    @(posedge clk);
    cpu_sfr_req <= 1'b1;
    cpu_sfr_we <= we;
    cpu_sfr_addr <= a;
    cpu_sfr_wdata <= d;
    @(posedge clk);
    cpu_sfr_req <= 1'b0;
    // released qualifiers flip so stale values cannot pass
    cpu_sfr_addr <= ~a;
    cpu_sfr_wdata <= ~d;
    @(posedge clk);
    rd = cpu_sfr_rdata;
    viol = cpu_sfr_violation;
  endtask : sfr_op
  task automatic mem_op(input mmac_op_t op, input logic [15:0] a, output logic viol,
                        output logic gr, output logic w, output logic [15:0] pa);
    int n;
    @(posedge clk);
    cpu_mem_req <= 1'b1;
    cpu_mem <= '{addr: a, op: op, wdata: 8'h3c};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_mem_done !== 1'b1 && n < 300);
    viol = cpu_mem_violation;
    gr = mem_req;
    w = mem_we;
    pa = mem_addr;
    cpu_mem_req <= 1'b0;
    cpu_mem <= ~{a, op, 8'h3c};
  endtask : mem_op
endmodule : mmac_cpu_model

// >>> dv/mmac_access_ctrl_bench.sv
// self-checking bench for the access control block
`timescale 1ns/1ns
module mmac_access_ctrl_bench;
  import mmac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, program_status_upper = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, cpu_mem_req, cpu_mem_done, cpu_mem_violation, mem_req, mem_we;
  logic cpu_sfr_req, cpu_sfr_we, cpu_sfr_done, cpu_sfr_violation, sfr_file_we;
  logic [15:0] mem_addr, pa;
  logic [7:0] mem_wdata, cpu_sfr_addr, cpu_sfr_wdata, cpu_sfr_rdata, sfr_file_rdata;
  logic [7:0] sfr_file_addr, sfr_file_wdata, r8;
  mmac_mode_t cpu_mode;
  mmac_mem_req_t cpu_mem;
  logic v, g, w;
  int bad_count = 0, n_checks = 0, cyc = 0;
  logic [1:0] mctl [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [7:0] mpsu [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  mmac_mode_t mexp [5] = '{MODE_BOOT, MODE_TEST, MODE_CLS, MODE_SYSTEM, MODE_USER};
  // granted groups per mode, bit order follows gadr
  logic [4:0] gmask [5] = '{5'h1f, 5'h1f, 5'h1a, 5'h1b, 5'h12};
  logic [7:0] gadr [5] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'hc0};
  mmac_access_ctrl u_mmac_access_ctrl (.*);
  mmac_cpu_model u_mmac_cpu_model (.*);
  always #5 clk = ~clk;
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic av_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) bad_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av_op
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_op(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av_op(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk
  task automatic set_mode(input logic [1:0] c, input logic [7:0] p);
    program_status_upper <= p;
    wr(OFS_CTRL, {30'h0, c});
    // mode register trails its inputs by a cycle
    repeat (2) @(posedge clk);
  endtask : set_mode
  task automatic seg(input logic [7:0] i, input logic [15:0] f, input logic [15:0] l,
                     input logic [15:0] o, input logic [3:0] r);
    wr(OFS_SEG_INDEX, {24'h0, i});
    wr(OFS_SEG_FIRST, {16'h0, f});
    wr(OFS_SEG_LAST, {16'h0, l});
    wr(OFS_SEG_OFFSET, {16'h0, o});
    wr(OFS_SEG_RIGHTS, {28'h0, r});
  endtask : seg
  task automatic mem_chk(input mmac_op_t op, input logic [15:0] a, input logic ge,
                         input logic [15:0] pe);
    u_mmac_cpu_model.mem_op(op, a, v, g, w, pa);
    check(v, !ge);
    check(g, ge);
    check(w, ge && op == OP_WRITE);
    if (ge) check(pa, pe);
    check(cpu_mem_done, 1'b1);
    if (ge && op == OP_WRITE) check(mem_wdata, 8'h3c);
  endtask : mem_chk
  task automatic sfr_chk(input logic we, input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] re, input logic ve);
    u_mmac_cpu_model.sfr_op(we, a, d, r8, v);
    if (!we) check(r8, re);
    check(v, ve);
  endtask : sfr_chk
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL, 32'h1);
    rd_chk(OFS_TABLE_PTR, 32'h0);
    rd_chk(8'h3c, 32'h0);
    for (int m = 0; m < 5; m++) begin
      set_mode(mctl[m], mpsu[m]);
      check(cpu_mode, mexp[m]);
      for (int k = 0; k < 5; k++)
        sfr_chk(1'b0, gadr[k], 8'h00, gmask[m][k] ? gadr[k] ^ 8'h5a : 8'h00,
                !gmask[m][k]);
    end
    set_mode(2'h0, 8'h80);
    mem_chk(OP_READ, 16'h1234, 1'b1, 16'h1234);
    mem_chk(OP_WRITE, 16'h0100, 1'b0, 16'h0);
    mem_chk(OP_WRITE, 16'hc010, 1'b1, 16'hc010);
    mem_chk(OP_EXEC, 16'h8100, 1'b0, 16'h0);
    set_mode(2'h1, 8'h00);
    mem_chk(OP_READ, 16'h0100, 1'b1, 16'h0100);
    mem_chk(OP_READ, 16'h1234, 1'b0, 16'h0);
    wr(OFS_TABLE_PTR, 32'h10);
    rd_chk(OFS_TABLE_PTR, 32'h10);
    for (int i = 0; i < 64; i++) seg(8'(i + 16), 16'h0, 16'h0, 16'h0, 4'h0);
    seg(8'h10, 16'h0000, 16'hffff, 16'h2000, 4'h8);
    seg(8'h11, 16'h0000, 16'h00ff, 16'h1000, 4'hd);
    seg(8'h12, 16'h0000, 16'h00ff, 16'hc000, 4'h3);
    set_mode(2'h0, 8'h00);
    mem_chk(OP_EXEC, 16'h0010, 1'b1, 16'h1010);
    sfr_chk(1'b0, 8'h40, 8'h00, 8'h40 ^ 8'h5a, 1'b0);
    mem_chk(OP_WRITE, 16'h0020, 1'b1, 16'hc020);
    mem_chk(OP_EXEC, 16'h0200, 1'b0, 16'h0);
    rd_chk(OFS_VIOL_ADDR, 32'h200);
    rd_chk(OFS_STATUS, 32'hc4);
    sfr_chk(1'b1, 8'h20, 8'hff, 8'h00, 1'b1);
    sfr_chk(1'b1, 8'h40, 8'h77, 8'h00, 1'b0);
    set_mode(2'h1, 8'h00);
    sfr_chk(1'b0, 8'h20, 8'h00, 8'h20 ^ 8'h5a, 1'b0);
    sfr_chk(1'b0, 8'h40, 8'h00, 8'h77, 1'b0);
    conclude();
  end
endmodule : mmac_access_ctrl_bench
bind mmac_access_ctrl mmac_access_ctrl_properties u_mmac_access_ctrl_properties (.*);
